// >>> sep_pkg.sv
// package of constants, encodings and state types for the serial eeprom command block
package sep_pkg;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_AW = 4;

  // ----------------------------------------
  // status word layout and reset value
  // ----------------------------------------
  localparam int ST_RDY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LO_BIT = 2;
  localparam int ST_BP_HI_BIT = 3;
  localparam int ST_PEN_BIT = 7;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] STAT_BUSY = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // ----------------------------------------
  // opcodes (bit 3 is don't care or address bit 8)
  // ----------------------------------------
  localparam logic [3:0] OPC_HI = 4'h0;
  localparam logic [2:0] OPC_SET_WEL = 3'h6;
  localparam logic [2:0] OPC_CLR_WEL = 3'h4;
  localparam logic [2:0] OPC_RD_STAT = 3'h5;
  localparam logic [2:0] OPC_WR_STAT = 3'h1;
  localparam logic [2:0] OPC_RD_ARR = 3'h3;
  localparam logic [2:0] OPC_WR_ARR = 3'h2;

  // ----------------------------------------
  // protected region bounds
  // ----------------------------------------
  localparam logic [8:0] PROT_QTR_BASE = 9'h180;
  localparam logic [8:0] PROT_HALF_BASE = 9'h100;

  // ----------------------------------------
  // timing: self-timed write cycle, longest time rounds down
  // ----------------------------------------
  localparam int T_WRITE_MS = 5;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_CYCLES = (T_WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // ----------------------------------------
  // frame states and pending operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_RSTAT = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } sep_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SET_WEL = 3'b001,
    OP_CLR_WEL = 3'b010,
    OP_WR_STAT = 3'b011,
    OP_WR_ARR = 3'b100,
    OP_RD_ARR = 3'b101
  } sep_op_t;

  // whole state of the command block
  typedef struct packed {
    sep_state_t st;
    sep_op_t pend;
    logic [2:0] ibit;
    logic [7:0] sin;
    logic [2:0] obit;
    logic [7:0] osh;
    logic so;
    logic oe;
    logic [8:0] waddr;
    logic [8:0] raddr;
    logic [7:0] sdata;
    logic [PAGE_BYTES-1:0] mask;
    logic [PAGE_BYTES-1:0][7:0] page;
    logic wel;
    logic [1:0] bp;
    logic pen;
    logic busy;
    logic busy_stat;
    logic [CNT_W-1:0] cnt;
    logic [1:0] new_bp;
    logic new_pen;
    logic sck_d;
    logic cs_d;
  } sep_regs_t;

  // true when the address lies in the block selected by the protect pair
  function automatic logic sep_is_prot(input logic [1:0] bp, input logic [8:0] a);
    case (bp)
      2'b01: sep_is_prot = (a >= PROT_QTR_BASE);
      2'b10: sep_is_prot = (a >= PROT_HALF_BASE);
      2'b11: sep_is_prot = 1'b1;
      default: sep_is_prot = 1'b0;
    endcase
  endfunction

  // status word as seen on the serial output
  function automatic logic [7:0] sep_status(input logic busy, input logic pen,
                                            input logic [1:0] bp, input logic wel);
    logic [7:0] v;
    v = STAT_RST;
    v[ST_PEN_BIT] = pen;
    v[ST_BP_HI_BIT] = bp[1];
    v[ST_BP_LO_BIT] = bp[0];
    v[ST_WEL_BIT] = wel;
    sep_status = busy ? STAT_BUSY : v;
  endfunction

endpackage

// >>> sep_sync.sv
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module sep_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage read only by the second
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// >>> sep_fifo.sv
// small valid/ready buffer with flush, used to prefetch array bytes
`timescale 1ns/1ps
module sep_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rp_q];
  assign push = i_valid && o_ready && !i_flush;
  assign pop = o_valid && i_ready && !i_flush;

  // pointers wrap at depth, not at a power of two
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset, contents qualified by the count
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end

endmodule

// >>> sep_eeprom.sv
// serial eeprom command decoder, status word, protection and array
//
// Function
// - status word read-only when hardware protection active or latch clear
// - status bit 0 is busy flag; when busy only status read accepted
// - bit 1 is write latch; nothing writable while it is 0
// - bits 2 and 3 are block protect bits, reset to 0
// - bits 4 to 6 are not stored and read as 0
// - during internal write the whole status word reads all ones
// - protect pair selects none, 180h-1FFh, 100h-1FFh or entire array
// - input bits sampled on sck rise, msb first, opcode then address/data
// - output bits shifted on sck fall, msb first
// - opcodes for set latch, clear latch and status read
// - status write opcode; array read and array write opcodes with address bit 8
// - latch cleared after clear-latch, status write or array write
// - status byte repeats while clock runs and chip select low
// - status write ignored unless latch set and hardware protection off
// - status fields change only when internal write completes
// - pin enable may go 1 to 0 only with protect pin high
// - array read continues sequentially, wrapping from last address to 0
// - array write limited to one 16-byte page, address wraps in page
// - protected locations never written, others only with latch set
// - hardware protection is pin low with pin enable set
// - serial output high impedance while chip select high
`timescale 1ns/1ps
module sep_eeprom #(
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES,
  parameter int PREFETCH_DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe
);

  localparam int MEM_BYTES = 1 << sep_pkg::ADDR_W;
  localparam int CNT_W = sep_pkg::CNT_W;

  sep_pkg::sep_regs_t r_q, r_d;
  logic [7:0] mem_q [MEM_BYTES];
  logic [3:0] pins_s;
  logic s_cs, s_sck, s_si, s_wp;
  logic sck_rise, sck_fall, cs_rise, hwp;
  logic [7:0] in_byte, out_byte, stat_val, f_data;
  logic byte_done, opc_ok, commit, flush, push, pop;
  logic f_ready, f_valid;

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  sep_sync #(
    .W(4),
    .RST_VAL(4'h9)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_wp_n, i_si, i_sck, i_cs_n}),
    .o_sync(pins_s)
  );

  // edges come from the synchronised copy against its delayed copy
  assign s_cs = pins_s[0];
  assign s_sck = pins_s[1];
  assign s_si = pins_s[2];
  assign s_wp = pins_s[3];
  assign sck_rise = s_sck && !r_q.sck_d;
  assign sck_fall = !s_sck && r_q.sck_d;
  assign cs_rise = s_cs && !r_q.cs_d;
  assign hwp = !s_wp && r_q.pen;
  assign in_byte = {r_q.sin[6:0], s_si};
  assign byte_done = !s_cs && sck_rise && (r_q.ibit == 3'd7);
  assign stat_val = sep_pkg::sep_status(r_q.busy, r_q.pen, r_q.bp, r_q.wel);
  assign opc_ok = (in_byte[7:4] == sep_pkg::OPC_HI) &&
                  (in_byte[2:0] != 3'h0) && (in_byte[2:0] != 3'h7);

  // ----------------------------------------
  // read prefetch buffer
  // ----------------------------------------
  // two entries cover the sync latency between address and first output bit
  sep_fifo #(
    .W(8),
    .DEPTH(PREFETCH_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_flush(flush),
    .i_valid(push),
    .o_ready(f_ready),
    .i_data(mem_q[r_q.raddr]),
    .o_valid(f_valid),
    .i_ready(pop),
    .o_data(f_data)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    commit = 1'b0;
    flush = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    out_byte = sep_pkg::FILL_BYTE;
    r_d.sck_d = s_sck;
    r_d.cs_d = s_cs;
    // self-timed write cycle; fields settle only at its end
    if (r_q.busy) begin
      if (r_q.cnt == '0) begin
        r_d.busy = 1'b0;
        r_d.wel = 1'b0;
        commit = !r_q.busy_stat;
        if (r_q.busy_stat) begin
          r_d.bp = r_q.new_bp;
          r_d.pen = r_q.new_pen;
        end
      end else begin
        r_d.cnt = r_q.cnt - 1'b1;
      end
    end
    if (s_cs) begin
      // standby: frame state dropped, output released
      r_d.st = sep_pkg::ST_CMD;
      r_d.ibit = 3'd0;
      r_d.obit = 3'd0;
      r_d.oe = 1'b0;
      r_d.pend = sep_pkg::OP_NONE;
      flush = 1'b1;
      if (cs_rise) begin
        case (r_q.pend)
          sep_pkg::OP_SET_WEL: r_d.wel = 1'b1;
          sep_pkg::OP_CLR_WEL: r_d.wel = 1'b0;
          sep_pkg::OP_WR_STAT: begin
            if (r_q.wel && !hwp) begin
              r_d.busy = 1'b1;
              r_d.busy_stat = 1'b1;
              r_d.cnt = CNT_W'(WRITE_CYCLES - 1);
              r_d.new_bp = r_q.sdata[sep_pkg::ST_BP_HI_BIT:sep_pkg::ST_BP_LO_BIT];
              // pin enable only drops with the pin high
              r_d.new_pen = (r_q.pen && !s_wp) ? 1'b1 : r_q.sdata[sep_pkg::ST_PEN_BIT];
            end
          end
          sep_pkg::OP_WR_ARR: begin
            if (r_q.wel && (r_q.mask != '0)) begin
              r_d.busy = 1'b1;
              r_d.busy_stat = 1'b0;
              r_d.cnt = CNT_W'(WRITE_CYCLES - 1);
            end
          end
          default: r_d.pend = sep_pkg::OP_NONE;
        endcase
      end
    end else begin
      if (sck_rise) begin
        r_d.sin = in_byte;
        r_d.ibit = r_q.ibit + 3'd1;
      end
      if (byte_done) begin
        case (r_q.st)
          sep_pkg::ST_CMD: begin
            if (!opc_ok) begin
              r_d.st = sep_pkg::ST_IGNORE;
            end else if (r_q.busy && (in_byte[2:0] != sep_pkg::OPC_RD_STAT)) begin
              r_d.st = sep_pkg::ST_IGNORE;
            end else begin
              case (in_byte[2:0])
                sep_pkg::OPC_SET_WEL: r_d.pend = sep_pkg::OP_SET_WEL;
                sep_pkg::OPC_CLR_WEL: r_d.pend = sep_pkg::OP_CLR_WEL;
                sep_pkg::OPC_RD_STAT: begin
                  r_d.st = sep_pkg::ST_RSTAT;
                  r_d.oe = 1'b1;
                end
                sep_pkg::OPC_WR_STAT: begin
                  r_d.st = sep_pkg::ST_WDATA;
                  r_d.pend = sep_pkg::OP_WR_STAT;
                end
                sep_pkg::OPC_RD_ARR: begin
                  r_d.st = sep_pkg::ST_ADDR;
                  r_d.pend = sep_pkg::OP_RD_ARR;
                  r_d.waddr = {in_byte[3], 8'h00};
                end
                default: begin
                  r_d.st = sep_pkg::ST_ADDR;
                  r_d.pend = sep_pkg::OP_WR_ARR;
                  r_d.waddr = {in_byte[3], 8'h00};
                  r_d.mask = '0;
                end
              endcase
            end
          end
          sep_pkg::ST_ADDR: begin
            r_d.waddr = {r_q.waddr[8], in_byte};
            r_d.raddr = {r_q.waddr[8], in_byte};
            if (r_q.pend == sep_pkg::OP_RD_ARR) begin
              r_d.st = sep_pkg::ST_RDATA;
              r_d.oe = 1'b1;
              r_d.pend = sep_pkg::OP_NONE;
              flush = 1'b1;
            end else begin
              r_d.st = sep_pkg::ST_WDATA;
            end
          end
          sep_pkg::ST_WDATA: begin
            if (r_q.pend == sep_pkg::OP_WR_STAT) begin
              r_d.sdata = in_byte;
            end else begin
              // later bytes overwrite earlier ones at the same page slot
              r_d.page[r_q.waddr[3:0]] = in_byte;
              r_d.mask[r_q.waddr[3:0]] = 1'b1;
              r_d.waddr = {r_q.waddr[8:4], r_q.waddr[3:0] + 4'd1};
            end
          end
          default: r_d.st = r_q.st;
        endcase
      end
      // output shifter, one bit per falling sck
      if (sck_fall && r_q.oe) begin
        if (r_q.obit == 3'd0) begin
          if (r_q.st == sep_pkg::ST_RSTAT) begin
            out_byte = stat_val;
          end else begin
            pop = 1'b1;
            out_byte = f_valid ? f_data : sep_pkg::FILL_BYTE;
          end
          r_d.so = out_byte[7];
          r_d.osh = {out_byte[6:0], 1'b0};
        end else begin
          r_d.so = r_q.osh[7];
          r_d.osh = {r_q.osh[6:0], 1'b0};
        end
        r_d.obit = r_q.obit + 3'd1;
      end
      // prefetch runs ahead and stalls on a full buffer
      if ((r_q.st == sep_pkg::ST_RDATA) && f_ready && !flush) begin
        push = 1'b1;
        r_d.raddr = r_q.raddr + 9'd1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_q <= '0;
      r_q.cs_d <= 1'b1;
      r_q.wel <= sep_pkg::STAT_RST[sep_pkg::ST_WEL_BIT];
      r_q.bp <= sep_pkg::STAT_RST[sep_pkg::ST_BP_HI_BIT:sep_pkg::ST_BP_LO_BIT];
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // array storage and page commit
  // ----------------------------------------
  // every loaded page slot lands in one cycle; unloaded and protected slots are skipped
  always_ff @(posedge i_ref_clk) begin
    if (commit) begin
      for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
        if (r_q.mask[i] && !sep_pkg::sep_is_prot(r_q.bp, {r_q.waddr[8:4], 4'(i)})) begin
          mem_q[{r_q.waddr[8:4], 4'(i)}] <= r_q.page[i];
        end
      end
    end
  end

  assign o_so = r_q.so;
  assign o_so_oe = r_q.oe && !s_cs;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  property p_so_idle;
    s_cs |=> !r_q.oe;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("output driven in standby");
  property p_busy_all_ones;
    r_q.busy |-> (stat_val == 8'hFF);
  endproperty
  a_busy_all_ones: assert property (p_busy_all_ones) else $error("status not ff when busy");
  property p_idle_stat_bits;
    !r_q.busy |-> (stat_val[6:4] == 3'b000) && !stat_val[0] && (stat_val[1] == r_q.wel);
  endproperty
  a_idle_stat_bits: assert property (p_idle_stat_bits) else $error("idle status bits wrong");
  property p_busy_refuse;
    (byte_done && r_q.st == sep_pkg::ST_CMD && r_q.busy && in_byte[2:0] != sep_pkg::OPC_RD_STAT)
      |=> (r_q.st == sep_pkg::ST_IGNORE) && (r_q.pend == sep_pkg::OP_NONE);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("command taken while busy");
  property p_bad_opc;
    (byte_done && r_q.st == sep_pkg::ST_CMD &&
     (in_byte[7:4] != 4'h0 || in_byte[2:0] == 3'h0 || in_byte[2:0] == 3'h7))
      |=> (r_q.st == sep_pkg::ST_IGNORE) ##1 (r_q.st == sep_pkg::ST_IGNORE || s_cs);
  endproperty
  a_bad_opc: assert property (p_bad_opc) else $error("bad opcode not ignored");
  property p_write_needs_wel;
    $rose(r_q.busy) |-> $past(r_q.wel) && r_q.wel;
  endproperty
  a_write_needs_wel: assert property (p_write_needs_wel) else $error("write without latch");
  property p_wel_cleared;
    $fell(r_q.busy) |-> !r_q.wel;
  endproperty
  a_wel_cleared: assert property (p_wel_cleared) else $error("latch kept after write");
  property p_write_status_cmd_refused;
    (cs_rise && r_q.pend == sep_pkg::OP_WR_STAT && (!r_q.wel || hwp)) |=> !r_q.busy ##1 !r_q.busy;
  endproperty
  a_write_status_cmd_refused: assert property (p_write_status_cmd_refused) else $error("status write not refused");
  property p_bp_hold_busy;
    (r_q.busy && $past(r_q.busy)) |-> $stable(r_q.bp) && $stable(r_q.pen);
  endproperty
  a_bp_hold_busy: assert property (p_bp_hold_busy) else $error("status changed mid cycle");
  property p_hwp_lock;
    (hwp && !r_q.busy) |=> $stable(r_q.bp) && $stable(r_q.pen);
  endproperty
  a_hwp_lock: assert property (p_hwp_lock) else $error("protect bits changed under pin");
  property p_read_wrap;
    (push && r_q.raddr == 9'h1FF) |=> (r_q.raddr == 9'h000);
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");

  c_write_cycle: cover property ($fell(r_q.busy) && !r_q.busy_stat);
  c_status_write: cover property ($fell(r_q.busy) && r_q.busy_stat);
  c_status_read: cover property (r_q.st == sep_pkg::ST_RSTAT && sck_fall && r_q.obit == 3'd0);
  c_ignored: cover property (r_q.st == sep_pkg::ST_IGNORE);

endmodule

// >>> sep_spi_master.sv
// bus master model that drives the serial pins of the eeprom command block
`timescale 1ns/1ps
module sep_spi_master (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  int half = 40;
  logic last_q = 1'b0;
  logic [7:0] rx;
  event got;
  // a released output shows the inverse of its last level, so a stale copy never passes
  wire line = i_so_oe ? i_so : ~last_q;

  // ----------------------------------------
  // pins and line tracking
  // ----------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  always @(i_so or i_so_oe) begin
    if (i_so_oe) begin
      last_q = i_so;
    end
  end

  // ----------------------------------------
  // frame tasks, clock idles low between frames
  // ----------------------------------------
  task automatic start();
    o_cs_n = 1'b0;
    #(half);
  endtask

  // one byte out on si, one byte in from the output line, msb first
  task automatic xfer(input logic [7:0] tx, input bit chk);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 1'b0;
      o_si = tx[i];
      #(half);
      rx[i] = line;
      o_sck = 1'b1;
      #(half);
    end
    if (chk) begin
      ->got;
    end
  endtask

  // chip select rises before any further rising clock edge
  task automatic stop();
    o_sck = 1'b0;
    #(half);
    o_cs_n = 1'b1;
    #(2 * half);
  endtask
endmodule

// >>> sep_eeprom_test.sv
// self-checking testbench for the serial eeprom command block
`timescale 1ns/1ps
module sep_eeprom_test;
  localparam int WCYC = 400;
  logic i_ref_clk;
  logic i_reset_n;
  logic i_wp_n;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 60;
  logic [7:0] exp_q[$];
  logic [7:0] mem [0:511];
  logic [1:0] bp;

  sep_eeprom #(.WRITE_CYCLES(WCYC), .PREFETCH_DEPTH(2)) uut (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_cs_n(cs_n),
    .i_sck(sck),
    .i_si(si),
    .i_wp_n(i_wp_n),
    .o_so(so),
    .o_so_oe(so_oe)
  );

  sep_spi_master m (
    .o_cs_n(cs_n),
    .o_sck(sck),
    .o_si(si),
    .i_so(so),
    .i_so_oe(so_oe)
  );

  // ----------------------------------------
  // clock, compare and closing report
  // ----------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp || $isunknown(seen)) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watcher: each received byte is matched against the oldest note
  initial begin
    forever begin
      @(m.got);
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value serial byte expected none seen %h", m.rx);
      end else begin
        check("serial byte", m.rx, exp_q.pop_front());
      end
    end
  end

  // hang guard, far above the length of the whole sequence
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    num_errors++;
    summarize();
  end

  // ----------------------------------------
  // frame helpers
  // ----------------------------------------
  function automatic bit prot(input logic [8:0] a);
    return bp == 2'b11 || (bp == 2'b10 && a >= 9'h100) || (bp == 2'b01 && a >= 9'h180);
  endfunction

  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input bit two);
    m.start();
    m.xfer(b0, 1'b0);
    if (two) begin
      m.xfer(b1, 1'b0);
    end
    m.stop();
  endtask

  // write cycle length is fixed by the parameter, margin covers pin sync
  task automatic settle();
    repeat (WCYC + 20) @(negedge i_ref_clk);
  endtask

  task automatic rd_stat(input logic [7:0] e, input int n);
    m.start();
    m.xfer(8'h05, 1'b0);
    repeat (n) begin
      exp_q.push_back(e);
      m.xfer(8'h00, 1'b1);
    end
    m.stop();
  endtask

  // page write; the shadow copy only changes where the block may change
  task automatic wr_arr(input logic [8:0] a, input int n, input bit en);
    logic [7:0] d;
    logic [3:0] lo;
    if (en) begin
      send(8'h06, 8'h00, 1'b0);
    end
    m.start();
    m.xfer({4'h0, a[8], 3'h2}, 1'b0);
    m.xfer(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      lo = a[3:0] + 4'(i);
      if (en && !prot({a[8:4], lo})) begin
        mem[{a[8:4], lo}] = d;
      end
      m.xfer(d, 1'b0);
    end
    m.stop();
    settle();
  endtask

  task automatic rd_arr(input logic [8:0] a, input int n);
    m.start();
    m.xfer({4'h0, a[8], 3'h3}, 1'b0);
    m.xfer(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[9'(a + 9'(i))]);
      m.xfer(8'h00, 1'b1);
    end
    m.stop();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_reset_n = 1'b0;
    i_wp_n = 1'b1;
    bp = 2'b00;
    repeat (16) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    repeat (5) @(negedge i_ref_clk);
    check("output enable idle", {7'h00, so_oe}, 8'h00);
    rd_stat(8'h00, 2);
    m.half = 120;
    rd_stat(8'h00, 1);
    m.half = 40;
    send(8'h06, 8'h00, 1'b0);
    rd_stat(8'h02, 1);
    send(8'h04, 8'h00, 1'b0);
    rd_stat(8'h00, 1);
    send(8'h01, 8'h8C, 1'b1);
    settle();
    rd_stat(8'h00, 1);
    send(8'h07, 8'h06, 1'b1);
    rd_stat(8'h00, 1);
    wr_arr(9'h1FF, 1, 1'b1);
    wr_arr(9'h000, 1, 1'b1);
    rd_arr(9'h1FF, 2);
    rd_stat(8'h00, 1);
    wr_arr(9'h17E, 17, 1'b1);
    rd_arr(9'h170, 16);
    wr_arr(9'h060, 1, 1'b1);
    wr_arr(9'h060, 1, 1'b0);
    rd_arr(9'h060, 1);
    // status write, then probe it while the write cycle runs
    send(8'h06, 8'h00, 1'b0);
    send(8'h01, 8'hF4, 1'b1);
    rd_stat(8'hFF, 1);
    send(8'h06, 8'h00, 1'b0);
    settle();
    bp = 2'b01;
    rd_stat(8'h84, 1);
    // pin protection holds the status word but not the array
    i_wp_n = 1'b0;
    send(8'h06, 8'h00, 1'b0);
    send(8'h01, 8'h00, 1'b1);
    settle();
    rd_stat(8'h86, 1);
    wr_arr(9'h050, 1, 1'b1);
    rd_arr(9'h050, 1);
    i_wp_n = 1'b1;
    send(8'h06, 8'h00, 1'b0);
    send(8'h01, 8'h00, 1'b1);
    settle();
    bp = 2'b00;
    rd_stat(8'h00, 1);
    // every protect code against the three regions
    for (int k = 0; k < 4; k++) begin
      bp = 2'(k);
      send(8'h06, 8'h00, 1'b0);
      send(8'h01, {4'h0, bp, 2'h0}, 1'b1);
      settle();
      rd_stat({4'h0, bp, 2'h0}, 1);
      wr_arr(9'h0F0, 2, 1'b1);
      wr_arr(9'h170, 2, 1'b1);
      wr_arr(9'h1F0, 2, 1'b1);
      rd_arr(9'h0F0, 2);
      rd_arr(9'h170, 2);
      rd_arr(9'h1F0, 2);
    end
    check("output enable end", {7'h00, so_oe}, 8'h00);
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    summarize();
  end
endmodule
